//--- mrac_core_model.sv
// core-side model: issues access checks and collects answers
`timescale 1ns/10ps
module mrac_core_model (
    // clock
    input wire logic core_clk,
    // check request
    output logic chk_valid,
    output logic [31:0] chk_addr,
    output logic chk_priv,
    output mrac_pkg::mrac_acc_type chk_kind,
    // check answer
    input wire logic res_valid,
    input wire logic res_fault,
    input wire logic res_severe_fault,
    input wire logic res_shareable,
    input wire mrac_pkg::mrac_mem_type res_mem_type
);
    // last answer: fault, severe, shareable, type
    logic [4:0] got;
    // set when no answer came in time
    logic timed_out;
    // idle request at time zero
    initial begin
        chk_valid = 1'b0;
        chk_addr = 32'h00000000;
        chk_priv = 1'b0;
        chk_kind = mrac_pkg::MRAC_ACC_READ;
        got = 5'h00;
        timed_out = 1'b0;
    end
    // one request for one edge, then a bounded wait for the answer
    task automatic access(input logic [31:0] a, input logic p,
            input mrac_pkg::mrac_acc_type k);
        int i;
        @(posedge core_clk);
        chk_valid <= 1'b1;
        chk_addr <= a;
        chk_priv <= p;
        chk_kind <= k;
        @(posedge core_clk);
        chk_valid <= 1'b0;
        // released bus shows no stale address
        chk_addr <= ~a;
        timed_out = 1'b1;
        for (i = 0; i < 8; i++) begin
            @(negedge core_clk);
            if (res_valid === 1'b1) begin
                got = {res_fault, res_severe_fault, res_shareable,
                    res_mem_type};
                timed_out = 1'b0;
                break;
            end
        end
    endtask : access
endmodule : mrac_core_model

//--- mrac_params.svh
// constants for the region attribute check block
`ifndef MRAC_PARAMS_SVH
`define MRAC_PARAMS_SVH
// register byte offsets
`define MRAC_OFF_CTRL 12'h000
`define MRAC_OFF_SEL 12'h004
`define MRAC_OFF_BASE 12'h008
`define MRAC_OFF_ATTR 12'h00C
`define MRAC_OFF_STAT 12'h010
`define MRAC_OFF_IEN 12'h014
`define MRAC_OFF_ICLR 12'h018
// field positions
`define MRAC_NOEXEC_BIT 28
`define MRAC_PERM_HI 26
`define MRAC_PERM_LO 24
`define MRAC_TYPEXT_HI 21
`define MRAC_TYPEXT_LO 19
`define MRAC_S_BIT 18
`define MRAC_C_BIT 17
`define MRAC_B_BIT 16
`define MRAC_SUBDIS_HI 15
`define MRAC_SUBDIS_LO 8
`define MRAC_SIZE_HI 5
`define MRAC_SIZE_LO 1
`define MRAC_EN_BIT 0
// limits and reset values
`define MRAC_SIZE_MIN 5'h07
`define MRAC_ATTR_RST 32'h00000000
`define MRAC_CTRL_RST 3'h0
// writable bits of the attribute register
`define MRAC_ATTR_MASK 32'h173FFF3F
`endif

//--- mrac_pkg.sv
// types for the region attribute check block
package mrac_pkg;
    // decoded memory type
    typedef enum logic [1:0] {
        MRAC_MEM_STRONG = 2'h0,
        MRAC_MEM_DEVICE = 2'h1,
        MRAC_MEM_NORM_WT = 2'h2,
        MRAC_MEM_NORM_WB = 2'h3
    } mrac_mem_type;
    // access kind
    typedef enum logic [1:0] {
        MRAC_ACC_READ = 2'h0,
        MRAC_ACC_WRITE = 2'h1,
        MRAC_ACC_FETCH = 2'h2
    } mrac_acc_type;
    // answer state, one hot
    typedef enum logic [1:0] {
        MRAC_ST_IDLE = 2'b01,
        MRAC_ST_DONE = 2'b10
    } mrac_state_type;
endpackage : mrac_pkg

//--- mrac_region_if.sv
// one region's decoded view shared between checker pieces
`timescale 1ns/10ps
interface mrac_region_if;
    logic [31:0] attr; // region attribute and size word
    logic [31:0] base; // region base address
    logic [31:0] addr; // address under test
    logic hit; // address inside an enabled subregion
    logic sub_off; // address in region but subregion disabled
    modport owner (output attr, output base, output addr,
        input hit, input sub_off);
    modport matcher (input attr, input base, input addr,
        output hit, output sub_off);
endinterface : mrac_region_if

//--- mrac_region_match.sv
// address match of one region with subregion disables
`timescale 1ns/10ps
`include "mrac_params.svh"
module mrac_region_match (
    // region view
    mrac_region_if.matcher rgn
);
    logic [4:0] size_code; // region size code
    logic [31:0] hi_mask; // address bits above the region size
    logic [2:0] sub_idx; // subregion index of the address
    logic in_span; // address inside the aligned span
    logic [5:0] shamt; // size code plus one

    // size and span decode
    always_comb begin
        size_code = rgn.attr[`MRAC_SIZE_HI:`MRAC_SIZE_LO];
        shamt = {1'b0, size_code} + 6'h01;
        hi_mask = (shamt >= 6'h20) ? 32'h00000000
            : (32'hFFFFFFFF << shamt[4:0]);
        in_span = ((rgn.addr ^ rgn.base) & hi_mask) == 32'h00000000;
        // three bits below the top of the span pick a subregion
        sub_idx = 3'((rgn.addr >> (shamt - 6'h03)) & 32'h00000007);
        // bit 8 is the lowest address eighth, bit 15 the highest
        rgn.sub_off = in_span
            && rgn.attr[`MRAC_SUBDIS_LO + sub_idx];
        rgn.hit = in_span && !rgn.sub_off;
    end
endmodule : mrac_region_match

//--- mrac_top.sv
// region attribute check with apb register file and interrupt
`timescale 1ns/10ps
`include "mrac_params.svh"
module mrac_top #(
    parameter int NUM_REGIONS = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // access check request from the core
    input wire logic chk_valid,
    input wire logic [31:0] chk_addr,
    input wire logic chk_priv,
    input wire mrac_pkg::mrac_acc_type chk_kind,
    // check answer
    output logic res_valid,
    output logic res_fault,
    output logic res_severe_fault,
    output logic res_shareable,
    output mrac_pkg::mrac_mem_type res_mem_type,
    // interrupt
    output logic irq
);
    // at least one select bit, so a single region still has an index
    localparam int SELW = (NUM_REGIONS > 1) ? $clog2(NUM_REGIONS) : 1;

    // refuse region counts the select logic cannot serve
    if (NUM_REGIONS < 1 || NUM_REGIONS > 16) begin : g_bad_regions
        $error("mrac_top: NUM_REGIONS must be 1 to 16");
    end

    // register state
    logic [2:0] ctrl_reg, ctrl_next; // [0] enable, [2] background map
    logic [7:0] sel_reg, sel_next; // region select
    logic [31:0] attr_reg [NUM_REGIONS]; // attribute and size words
    logic [31:0] base_reg [NUM_REGIONS]; // base addresses
    logic [31:0] attr_next [NUM_REGIONS];
    logic [31:0] base_next [NUM_REGIONS];
    logic [1:0] stat_reg, stat_next; // [0] fault, [1] severe fault
    logic [1:0] ien_reg, ien_next; // interrupt enables
    // answer state
    mrac_pkg::mrac_state_type st_reg, st_next;
    logic fault_reg, fault_next;
    logic sev_reg, sev_next;
    logic shr_reg, shr_next;
    mrac_pkg::mrac_mem_type mt_reg, mt_next;
    logic [31:0] rd_reg, rd_next; // read data register

    // per region match results
    logic [NUM_REGIONS-1:0] hit_vec;
    logic [NUM_REGIONS-1:0] act_vec;

    // one matcher per region
    for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_rgn
        mrac_region_if rif ();
        assign rif.attr = attr_reg[g];
        assign rif.base = base_reg[g];
        assign rif.addr = chk_addr;
        mrac_region_match u_match (
            .rgn(rif.matcher)
        );
        // region needs its own enable and the global one
        assign act_vec[g] = attr_reg[g][`MRAC_EN_BIT]
            && ctrl_reg[0];
        assign hit_vec[g] = act_vec[g] && rif.hit;
    end

    // apb decode
    logic wr_en, rd_en, sel_ok;
    logic [SELW-1:0] sel_idx;
    always_comb begin
        wr_en = psel && penable && pwrite;
        rd_en = psel && !penable && !pwrite;
        sel_idx = SELW'(sel_reg);
        sel_ok = sel_reg < 8'(NUM_REGIONS);
    end

    // check decode: highest numbered hit wins
    logic any_hit;
    logic [31:0] win_attr;
    logic [2:0] perm_code;
    logic rd_ok, wr_ok, allow, is_fetch;
    always_comb begin
        any_hit = 1'b0;
        win_attr = 32'h00000000;
        for (int i = 0; i < NUM_REGIONS; i++) begin
            if (hit_vec[i]) begin
                any_hit = 1'b1;
                win_attr = attr_reg[i];
            end
        end
        perm_code = win_attr[`MRAC_PERM_HI:`MRAC_PERM_LO];
        rd_ok = 1'b0;
        wr_ok = 1'b0;
        unique case (perm_code)
            3'h0: begin
                rd_ok = 1'b0;
                wr_ok = 1'b0;
            end
            3'h1: begin
                rd_ok = chk_priv;
                wr_ok = chk_priv;
            end
            3'h2: begin
                rd_ok = 1'b1;
                wr_ok = chk_priv;
            end
            3'h3: begin
                rd_ok = 1'b1;
                wr_ok = 1'b1;
            end
            // reserved code: treated as no access, the safe choice
            3'h4: begin
                rd_ok = 1'b0;
                wr_ok = 1'b0;
            end
            3'h5: begin
                rd_ok = chk_priv;
                wr_ok = 1'b0;
            end
            default: begin // 110 and 111
                rd_ok = 1'b1;
                wr_ok = 1'b0;
            end
        endcase
        is_fetch = chk_kind == mrac_pkg::MRAC_ACC_FETCH;
        if (!ctrl_reg[0]) begin
            allow = 1'b1; // default map for all
        end else if (!any_hit) begin
            allow = chk_priv && ctrl_reg[2];
        end else if (is_fetch) begin
            // fetch needs read right and no-execute clear
            allow = rd_ok && !win_attr[`MRAC_NOEXEC_BIT];
        end else if (chk_kind == mrac_pkg::MRAC_ACC_WRITE) begin
            allow = wr_ok;
        end else begin
            allow = rd_ok;
        end
    end

    // memory type decode of the winning region
    mrac_pkg::mrac_mem_type mt_dec;
    logic shr_dec;
    always_comb begin
        // type extension is taken as 000; other values reserved
        mt_dec = mrac_pkg::mrac_mem_type'({win_attr[`MRAC_C_BIT],
            win_attr[`MRAC_B_BIT]});
        // shareable bit only matters for normal memory
        if (!any_hit || !ctrl_reg[0]) begin
            mt_dec = mrac_pkg::MRAC_MEM_STRONG;
            shr_dec = 1'b1;
        end else if (mt_dec == mrac_pkg::MRAC_MEM_NORM_WT
            || mt_dec == mrac_pkg::MRAC_MEM_NORM_WB) begin
            shr_dec = win_attr[`MRAC_S_BIT];
        end else begin
            shr_dec = 1'b1;
        end
    end

    // answer next state: result one cycle after request
    always_comb begin
        st_next = mrac_pkg::MRAC_ST_IDLE;
        fault_next = fault_reg;
        sev_next = sev_reg;
        shr_next = shr_reg;
        mt_next = mt_reg;
        if (chk_valid) begin
            st_next = mrac_pkg::MRAC_ST_DONE;
            fault_next = !allow;
            sev_next = !allow && is_fetch;
            shr_next = shr_dec;
            mt_next = mt_dec;
        end
    end

    // register file next state
    always_comb begin
        ctrl_next = ctrl_reg;
        sel_next = sel_reg;
        ien_next = ien_reg;
        for (int i = 0; i < NUM_REGIONS; i++) begin
            attr_next[i] = attr_reg[i];
            base_next[i] = base_reg[i];
        end
        // sticky events: the set wins over a same-cycle clear
        stat_next = stat_reg;
        if (wr_en && paddr == `MRAC_OFF_ICLR)
            stat_next = stat_reg & ~pwdata[1:0];
        if (chk_valid && !allow)
            stat_next[0] = 1'b1;
        if (chk_valid && !allow && is_fetch)
            stat_next[1] = 1'b1;
        if (wr_en) begin
            unique case (paddr)
                `MRAC_OFF_CTRL: ctrl_next = pwdata[2:0];
                `MRAC_OFF_SEL: sel_next = pwdata[7:0];
                `MRAC_OFF_BASE: begin
                    if (sel_ok)
                        base_next[sel_idx] = {pwdata[31:8], 8'h00};
                end
                `MRAC_OFF_ATTR: begin
                    if (sel_ok)
                        attr_next[sel_idx] = pwdata & `MRAC_ATTR_MASK;
                end
                `MRAC_OFF_IEN: ien_next = pwdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // read data, captured in the setup cycle
    always_comb begin
        rd_next = rd_reg;
        if (rd_en) begin
            unique case (paddr)
                `MRAC_OFF_CTRL: rd_next = {29'h0, ctrl_reg};
                `MRAC_OFF_SEL: rd_next = {24'h0, sel_reg};
                `MRAC_OFF_BASE:
                    rd_next = sel_ok ? base_reg[sel_idx] : 32'h0;
                `MRAC_OFF_ATTR:
                    rd_next = sel_ok ? attr_reg[sel_idx] : 32'h0;
                `MRAC_OFF_STAT: rd_next = {30'h0, stat_reg};
                `MRAC_OFF_IEN: rd_next = {30'h0, ien_reg};
                default: rd_next = 32'h00000000;
            endcase
        end
    end

    // all state registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= `MRAC_CTRL_RST;
            sel_reg <= 8'h00;
            stat_reg <= 2'h0;
            ien_reg <= 2'h0;
            rd_reg <= 32'h00000000;
            st_reg <= mrac_pkg::MRAC_ST_IDLE;
            fault_reg <= 1'b0;
            sev_reg <= 1'b0;
            shr_reg <= 1'b0;
            mt_reg <= mrac_pkg::MRAC_MEM_STRONG;
            for (int i = 0; i < NUM_REGIONS; i++) begin
                attr_reg[i] <= `MRAC_ATTR_RST;
                base_reg[i] <= 32'h00000000;
            end
        end else begin
            ctrl_reg <= ctrl_next;
            sel_reg <= sel_next;
            stat_reg <= stat_next;
            ien_reg <= ien_next;
            rd_reg <= rd_next;
            st_reg <= st_next;
            fault_reg <= fault_next;
            sev_reg <= sev_next;
            shr_reg <= shr_next;
            mt_reg <= mt_next;
            for (int i = 0; i < NUM_REGIONS; i++) begin
                attr_reg[i] <= attr_next[i];
                base_reg[i] <= base_next[i];
            end
        end
    end

    // outputs; apb answers with no wait state
    always_comb begin
        prdata = rd_reg;
        pready = 1'b1;
        pslverr = 1'b0;
        res_valid = st_reg == mrac_pkg::MRAC_ST_DONE;
        res_fault = fault_reg;
        res_severe_fault = sev_reg;
        res_shareable = shr_reg;
        res_mem_type = mt_reg;
        irq = |(stat_reg & ien_reg);
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_off_no_fault: assert property (
        chk_valid && !ctrl_reg[0] |=> res_valid && !res_fault)
        else $error("fault raised with protection off");
    a_noexec_fetch: assert property (
        chk_valid && ctrl_reg[0] && any_hit && is_fetch
        && win_attr[`MRAC_NOEXEC_BIT] |=> res_fault && res_severe_fault)
        else $error("fetch from no-execute region not faulted");
    a_perm_none: assert property (
        chk_valid && ctrl_reg[0] && any_hit && perm_code == 3'h0
        |=> res_fault)
        else $error("no-access code did not fault");
    a_perm_full: assert property (
        chk_valid && ctrl_reg[0] && any_hit
        && perm_code == 3'h3 && !is_fetch
        |=> !res_fault)
        else $error("full access code faulted");
    a_user_write_ro: assert property (
        chk_valid && ctrl_reg[0] && any_hit && !chk_priv
        && perm_code == 3'h2
        && chk_kind == mrac_pkg::MRAC_ACC_WRITE |=> res_fault)
        else $error("user write to read-only not faulted");
    a_ro_write: assert property (
        chk_valid && ctrl_reg[0] && any_hit && perm_code[2]
        && chk_kind == mrac_pkg::MRAC_ACC_WRITE |=> res_fault)
        else $error("write to read-only code not faulted");
    a_nohit_bg: assert property (
        chk_valid && ctrl_reg[0] && !any_hit
        |=> res_fault == !($past(chk_priv) && $past(ctrl_reg[2])))
        else $error("background map result wrong");
    a_region_active: assert property (
        !ctrl_reg[0] |-> hit_vec == '0)
        else $error("region hit while protection off");
    a_attr_sel_write: assert property (
        wr_en && paddr == `MRAC_OFF_ATTR && sel_ok
        |=> attr_reg[$past(sel_idx)] == ($past(pwdata) & `MRAC_ATTR_MASK))
        else $error("attribute write missed selected region");
    a_irq_level: assert property (
        stat_reg[0] && ien_reg[0] |-> irq)
        else $error("interrupt not raised");

    c_fault: cover property (chk_valid && !allow ##1 res_fault);
    c_fetch_sev: cover property (res_severe_fault);
    c_bg_ok: cover property (chk_valid && ctrl_reg[0] && !any_hit && allow);
    c_irq: cover property (irq);
endmodule : mrac_top

//--- test_mrac_top.sv
// self-checking bench for the region attribute check block
`timescale 1ns/10ps
`include "mrac_params.svh"
module test_mrac_top;
    logic core_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d, a1, bs, sb;
    logic chk_valid, chk_priv, res_valid, res_fault, res_severe_fault;
    logic res_shareable, irq, f;
    logic [31:0] chk_addr;
    mrac_pkg::mrac_acc_type chk_kind;
    mrac_pkg::mrac_mem_type res_mem_type;
    int n_errors, compares, x, pc, p, k, cb, s, z;
    int sz[3] = '{7, 12, 20};
    // clock, 50 ns period
    always #25 core_clk = ~core_clk;
    mrac_top u_mrac_top (.core_clk(core_clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chk_valid(chk_valid), .chk_addr(chk_addr),
        .chk_priv(chk_priv), .chk_kind(chk_kind), .res_valid(res_valid),
        .res_fault(res_fault), .res_severe_fault(res_severe_fault),
        .res_shareable(res_shareable), .res_mem_type(res_mem_type),
        .irq(irq));
    mrac_core_model u_mrac_core_model (.core_clk(core_clk),
        .chk_valid(chk_valid), .chk_addr(chk_addr), .chk_priv(chk_priv),
        .chk_kind(chk_kind), .res_valid(res_valid), .res_fault(res_fault),
        .res_severe_fault(res_severe_fault), .res_shareable(res_shareable),
        .res_mem_type(res_mem_type));
    // verdict and end of run
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    // one comparison
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk
    // one apb transfer, bounded wait on pready
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] wd, output logic [31:0] rdat);
        int i;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 8) begin
            n_errors++;
            summarize();
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] t;
        apb(1'b1, a, v, t);
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        apb(1'b0, a, 32'h00000000, v);
    endtask : rd
    // one check through the core model, masked compare
    task automatic acc(input logic [31:0] a, input int pr, input int kd,
            input logic [4:0] e, input logic [4:0] m);
        u_mrac_core_model.access(a, pr[0], mrac_pkg::mrac_acc_type'(kd[1:0]));
        if (u_mrac_core_model.timed_out) begin
            n_errors++;
            summarize();
        end
        chk({27'h0, e & m}, {27'h0, u_mrac_core_model.got & m});
    endtask : acc
    // attribute word from its fields
    function automatic logic [31:0] mk(input int nx, input int apc,
            input int sh, input int c, input int subregion_disable_mask, input int size,
            input int en);
        return {3'h0, nx[0], 1'b0, apc[2:0], 5'h00, sh[0], c[1:0],
            subregion_disable_mask[7:0], 2'h0, size[4:0], en[0]};
    endfunction : mk
    // expected permission from the access code
    function automatic logic ok(input int apc, input int pr, input int wt);
        case (apc)
            0, 4: return 1'b0;
            1: return pr[0];
            2: return pr[0] | ~wt[0];
            3: return 1'b1;
            5: return pr[0] & ~wt[0];
            default: return ~wt[0];
        endcase
    endfunction : ok
    // watchdog over the whole run
    initial begin
        repeat (100000) @(posedge core_clk);
        n_errors++;
        summarize();
    end
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        n_errors = 0;
        compares = 0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        // registers: reset values, mask, unmapped place
        rd(`MRAC_OFF_CTRL, d); chk(32'h00000000, d);
        rd(`MRAC_OFF_ATTR, d); chk(`MRAC_ATTR_RST, d);
        rd(12'h01C, d); chk(32'h00000000, d);
        chk(32'h00000000, {31'h0, pslverr});
        wr(`MRAC_OFF_ATTR, 32'hFFFFFFFF);
        rd(`MRAC_OFF_ATTR, d); chk(`MRAC_ATTR_MASK, d);
        $display("test registers done");
        // permissions for every code, privilege, kind, no-execute
        wr(`MRAC_OFF_CTRL, 32'h00000001);
        wr(`MRAC_OFF_BASE, 32'h00010000);
        for (x = 0; x < 2; x++) for (pc = 0; pc < 8; pc++) begin
            wr(`MRAC_OFF_ATTR, mk(x, pc, 0, 3, 0, 15, 1));
            for (p = 0; p < 2; p++) for (k = 0; k < 3; k++) begin
                f = ~ok(pc, p, k == 1) | (k == 2 && x == 1);
                acc(32'h00010040, p, k, {f, f & (k == 2), 3'h0},
                    5'h18);
            end
        end
        $display("test permissions done");
        // memory type and shareable decode
        for (cb = 0; cb < 4; cb++) for (s = 0; s < 2; s++) begin
            wr(`MRAC_OFF_ATTR, mk(0, 3, s, cb, 0, 15, 1));
            acc(32'h000100F0, 1, 0, {2'h0, cb < 2 ? 1'b1 : s[0], cb[1:0]},
                5'h1F);
        end
        $display("test memory types done");
        // sizes and each subregion disable bit
        bs = 32'h01000000;
        wr(`MRAC_OFF_BASE, bs);
        for (z = 0; z < 3; z++) begin
            sb = 32'h1 << (sz[z] - 2);
            wr(`MRAC_OFF_ATTR, mk(0, 3, 0, 3, 0, sz[z], 1));
            acc(bs + 8 * sb - 1, 1, 0, 5'h03, 5'h1F);
            acc(bs + 8 * sb, 1, 0, 5'h14, 5'h1F);
            for (k = 0; k < 8; k++) begin
                wr(`MRAC_OFF_ATTR, mk(0, 3, 0, 3, 1 << k, sz[z], 1));
                acc(bs + k * sb, 1, 0, 5'h14, 5'h1F);
                acc(bs + ((k + 1) % 8) * sb + sb - 1, 1, 0, 5'h03,
                    5'h1F);
            end
        end
        $display("test sizes and subregions done");
        // region enable, background map, global off
        wr(`MRAC_OFF_ATTR, mk(0, 3, 0, 3, 0, 15, 0));
        acc(bs + 32'h40, 1, 0, 5'h14, 5'h1F);
        wr(`MRAC_OFF_CTRL, 32'h00000005);
        acc(bs + 32'h40, 1, 0, 5'h04, 5'h1F);
        acc(bs + 32'h40, 0, 0, 5'h14, 5'h1F);
        wr(`MRAC_OFF_ATTR, mk(0, 0, 0, 3, 0, 15, 1));
        wr(`MRAC_OFF_CTRL, 32'h00000000);
        acc(bs + 32'h40, 0, 1, 5'h04, 5'h1F);
        $display("test enables done");
        // region select steers the attribute register
        a1 = mk(1, 5, 1, 1, 8'hA5, 9, 0);
        wr(`MRAC_OFF_SEL, 32'h00000001);
        wr(`MRAC_OFF_ATTR, a1);
        wr(`MRAC_OFF_SEL, 32'h00000000);
        rd(`MRAC_OFF_ATTR, d); chk(mk(0, 0, 0, 3, 0, 15, 1), d);
        wr(`MRAC_OFF_SEL, 32'h00000001);
        rd(`MRAC_OFF_ATTR, d); chk(a1, d);
        wr(`MRAC_OFF_SEL, 32'h00000009);
        wr(`MRAC_OFF_ATTR, 32'hFFFFFFFF);
        rd(`MRAC_OFF_ATTR, d); chk(32'h00000000, d);
        wr(`MRAC_OFF_SEL, 32'h00000000);
        $display("test select done");
        // interrupt: raise, mask, clear
        wr(`MRAC_OFF_ICLR, 32'h00000003);
        wr(`MRAC_OFF_IEN, 32'h00000000);
        wr(`MRAC_OFF_CTRL, 32'h00000001);
        acc(bs + 32'h40, 1, 2, 5'h18, 5'h18);
        rd(`MRAC_OFF_STAT, d); chk(32'h00000003, d);
        @(negedge core_clk); chk({31'h0, irq}, 32'h0);
        wr(`MRAC_OFF_IEN, 32'h00000002);
        @(negedge core_clk); chk({31'h0, irq}, 32'h1);
        rd(`MRAC_OFF_ICLR, d); chk(32'h00000000, d);
        wr(`MRAC_OFF_ICLR, 32'h00000003);
        rd(`MRAC_OFF_STAT, d); chk(32'h00000000, d);
        @(negedge core_clk); chk({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        summarize();
    end
endmodule : test_mrac_top
